//--- trc_pkg.sv
package trc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_VETO = 12'h004;
  localparam logic [11:0] ADDR_DELAY = 12'h008;
  localparam logic [11:0] ADDR_FRAME = 12'h00C;
  localparam logic [11:0] ADDR_CLEAR = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam logic [11:0] ADDR_COUNT = 12'h018;
  localparam logic [11:0] ADDR_MASK0 = 12'h100;
  localparam logic [11:0] ADDR_LATCH0 = 12'h200;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_XOBJ_BIT = 0;
  localparam int CTRL_ALLIN_BIT = 1;
  localparam int CTRL_DUAL_BIT = 2;
  localparam int STATUS_GLOBAL_BIT = 0;
  localparam int STATUS_CHECK_BIT = 1;
  localparam logic [8:0] VETO_RST = 9'h000;
  localparam logic [8:0] DELAY_RST = 9'h064;
  localparam logic [3:0] FRAME_RST = 4'h3;
  localparam logic [31:0] CLEAR_KEY = 32'h00000001;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int MAX_DELAY_NS = 3000;
  localparam int MAX_DELAY_CYC = MAX_DELAY_NS * CLK_MHZ / 1000;

  // ----------------------------------------------------------------
  // readout word kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRC_KIND_OBJ,
    TRC_KIND_XOBJ,
    TRC_KIND_INPUT,
    TRC_KIND_FLOW
  } trc_kind_t;

  typedef struct packed {
    logic valid;
    trc_kind_t kind;
    logic [6:0] chan;
    logic check;
    logic [15:0] count;
    logic [31:0] data;
  } trc_word_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } trc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } trc_apb_rsp_t;

endpackage

//--- trc_capture.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Function
// - one readout stream, copied to two drivers
// - objects, expanded objects, inputs; objects default
// - expanded objects off unless static setting
// - inputs tapped after deserialise and CRC check
// - default only errored inputs read out
// - per-channel mask excludes inputs, 104 channels
// - veto blocks input readout 0-511 ticks
// - delay memories, read after up to 3us
// - keep data only on accept and enabled
// - fixed-latency frame selection, overlapping frames allowed
// - frame length setting, three by default
// - flow word when nothing captured, never forwarded
// - selected words held in buffer before links
// - merger sends over six links per driver
// - send whenever non-empty, no backpressure expected
// - errored data zeroed realtime, raw to readout
// - check result ORs all channel errors
// - counter increments each cycle with any error
// - sticky per-channel latch until software clear
// - global flag ORs all latch bits
// - all readable, one command clears all
// - check result and count embedded in readout
// - ten-bit CRC per input link payload
// - settings reached by register transactions
module trc_capture #(
  parameter int NCH = 104,
  parameter int DEPTH = 512,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire trc_pkg::trc_apb_req_t apb_req,
  output trc_pkg::trc_apb_rsp_t apb_rsp,
  input wire logic [NCH-1:0] in_valid,
  input wire logic [NCH*32-1:0] in_data,
  input wire logic [NCH*10-1:0] in_crc_ok_n,
  input wire logic obj_valid,
  input wire logic [31:0] obj_data,
  input wire logic xobj_valid,
  input wire logic [31:0] xobj_data,
  input wire logic level1_accept,
  output logic [NCH*32-1:0] rt_data,
  output trc_pkg::trc_word_t ro_word_a,
  output trc_pkg::trc_word_t ro_word_b,
  output logic fifo_overflow
);

  localparam int AW = $clog2(DEPTH);
  localparam int FW = $clog2(FIFO_DEPTH);
  localparam int MW = (NCH + 31) / 32;
  localparam int CW = $clog2(NCH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic xobj_en;
    logic all_in;
    logic dual;
    logic [8:0] veto_len;
    logic [8:0] veto_cnt;
    logic [AW-1:0] delay;
    logic [3:0] frame;
    logic [DEPTH-1:0] acc_pipe;
    logic [3:0] frame_left;
    logic [NCH-1:0] mask;
    logic [NCH-1:0] latch;
    logic [15:0] err_cnt;
    logic check;
    logic [NCH-1:0] sel_pend;
    logic [FW:0] fcnt;
    logic [FW-1:0] fwr;
    logic [FW-1:0] frd;
    logic ovf;
    logic [AW-1:0] hold;
    logic xpend;
    trc_pkg::trc_word_t out;
    trc_pkg::trc_word_t out_b;
    trc_pkg::trc_apb_rsp_t rsp;
    logic [NCH*32-1:0] rt;
  } trc_state_t;

  trc_state_t s_q;
  trc_state_t s_d;

  // delay memories: objects, expanded objects, per-channel input plus error
  logic [31:0] obj_mem [DEPTH];
  logic [31:0] xobj_mem [DEPTH];
  logic [NCH-1:0] err_mem [DEPTH];
  logic [NCH*32-1:0] in_mem [DEPTH];
  trc_pkg::trc_word_t fifo [FIFO_DEPTH];

  // ----------------------------------------------------------------
  // per-channel CRC check and realtime suppression
  // ----------------------------------------------------------------
  logic [NCH-1:0] ch_err;
  logic [NCH*32-1:0] rt_next;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      assign ch_err[g] = in_valid[g] & (|in_crc_ok_n[g*10 +: 10]);
      assign rt_next[g*32 +: 32] = ch_err[g] ? 32'h00000000 : in_data[g*32 +: 32];
    end
  endgenerate

  // inputs come from the deserialisers on this clock, so no synchroniser
  always_ff @(posedge clock) begin
    obj_mem[s_q.wptr] <= obj_valid ? obj_data : 32'h00000000;
    xobj_mem[s_q.wptr] <= xobj_valid ? xobj_data : 32'h00000000;
    err_mem[s_q.wptr] <= ch_err;
    in_mem[s_q.wptr] <= in_data;
  end

  // selection source: an object, expanded-object or flow word per crossing plus held expanded objects and pending inputs
  logic [NCH-1:0] in_cand;
  logic any_in;
  logic [CW-1:0] first_in;
  logic [NCH-1:0] mem_err;
  assign mem_err = err_mem[s_q.rptr];
  // a draining crossing is read at its held slot; the writer reaches it
  // again only after DEPTH cycles, so delay plus drain must stay below that
  logic [NCH-1:0] hold_err;
  assign hold_err = err_mem[s_q.hold];

  always_comb begin
    any_in = 1'b0;
    first_in = '0;
    in_cand = s_q.sel_pend;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (in_cand[i]) begin
        any_in = 1'b1;
        first_in = CW'(i);
      end
    end
  end

  // register readback mux
  logic [31:0] rd;
  logic [11:0] a;
  int unsigned widx;
  always_comb begin
    a = apb_req.paddr;
    rd = 32'h00000000;
    widx = 0;
    case (a)
      trc_pkg::ADDR_CTRL: rd = {29'h0, s_q.dual, s_q.all_in, s_q.xobj_en};
      trc_pkg::ADDR_VETO: rd = {23'h0, s_q.veto_len};
      trc_pkg::ADDR_DELAY: rd = 32'(s_q.delay);
      trc_pkg::ADDR_FRAME: rd = {28'h0, s_q.frame};
      trc_pkg::ADDR_STATUS: rd = {30'h0, s_q.check, |s_q.latch};
      trc_pkg::ADDR_COUNT: rd = {16'h0, s_q.err_cnt};
      default: begin
        if (a >= trc_pkg::ADDR_MASK0 && a < trc_pkg::ADDR_MASK0 + 12'(MW * 4)) begin
          widx = 32'(a - trc_pkg::ADDR_MASK0) >> 2;
          for (int b = 0; b < 32; b++) begin
            if (widx * 32 + b < NCH) rd[b] = s_q.mask[widx * 32 + b];
          end
        end else if (a >= trc_pkg::ADDR_LATCH0 && a < trc_pkg::ADDR_LATCH0 + 12'(MW * 4)) begin
          widx = 32'(a - trc_pkg::ADDR_LATCH0) >> 2;
          for (int b = 0; b < 32; b++) begin
            if (widx * 32 + b < NCH) rd[b] = s_q.latch[widx * 32 + b];
          end
        end
      end
    endcase
  end

  logic mapped;
  always_comb begin
    mapped = (a <= trc_pkg::ADDR_COUNT) && (a[1:0] == 2'b00);
    if (a >= trc_pkg::ADDR_MASK0 && a < trc_pkg::ADDR_MASK0 + 12'(MW * 4)) mapped = 1'b1;
    if (a >= trc_pkg::ADDR_LATCH0 && a < trc_pkg::ADDR_LATCH0 + 12'(MW * 4)) mapped = 1'b1;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic wr;
  logic clr;
  logic push;
  logic pop;
  trc_pkg::trc_word_t pw;
  int unsigned mw;
  always_comb begin
    s_d = s_q;
    // write lands at the edge that completes the transfer
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & s_q.rsp.pready;
    clr = wr && a == trc_pkg::ADDR_CLEAR && apb_req.pwdata == trc_pkg::CLEAR_KEY;
    push = 1'b0;
    pw = '0;
    mw = 0;

    // apb: one wait state, answer on the second access cycle
    s_d.rsp.pready = apb_req.psel & apb_req.penable & ~s_q.rsp.pready;
    s_d.rsp.pslverr = apb_req.psel & apb_req.penable & ~s_q.rsp.pready & ~mapped;
    s_d.rsp.prdata = (apb_req.psel & apb_req.penable & ~apb_req.pwrite) ? rd : 32'h00000000;
    if (wr && mapped) begin
      case (a)
        trc_pkg::ADDR_CTRL: begin
          s_d.xobj_en = apb_req.pwdata[trc_pkg::CTRL_XOBJ_BIT];
          s_d.all_in = apb_req.pwdata[trc_pkg::CTRL_ALLIN_BIT];
          s_d.dual = apb_req.pwdata[trc_pkg::CTRL_DUAL_BIT];
        end
        trc_pkg::ADDR_VETO: s_d.veto_len = apb_req.pwdata[8:0];
        trc_pkg::ADDR_DELAY: s_d.delay = apb_req.pwdata[AW-1:0];
        trc_pkg::ADDR_FRAME: s_d.frame = apb_req.pwdata[3:0];
        default: begin
          if (a >= trc_pkg::ADDR_MASK0 && a < trc_pkg::ADDR_MASK0 + 12'(MW * 4)) begin
            mw = 32'(a - trc_pkg::ADDR_MASK0) >> 2;
            for (int b = 0; b < 32; b++) begin
              if (mw * 32 + b < NCH) s_d.mask[mw * 32 + b] = apb_req.pwdata[b];
            end
          end
        end
      endcase
    end

    // realtime output with errored channels suppressed
    s_d.rt = rt_next;

    // error bookkeeping: set beats the single clear
    s_d.check = |ch_err;
    if (clr) begin
      s_d.check = |ch_err;
      s_d.err_cnt = 16'(|ch_err);
      s_d.latch = ch_err;
    end else begin
      if (|ch_err) s_d.err_cnt = s_q.err_cnt + 16'h0001;
      s_d.latch = s_q.latch | ch_err;
    end

    // scrolling pointers: read lags write by the programmed delay
    s_d.wptr = s_q.wptr + AW'(1);
    s_d.rptr = s_q.wptr - s_q.delay + AW'(1);

    // accept history so that the frame opens at the delayed crossing
    s_d.acc_pipe = {s_q.acc_pipe[DEPTH-2:0], level1_accept};
    if (s_q.acc_pipe[s_q.delay] && s_q.frame != 4'h0) begin
      s_d.frame_left = s_q.frame; // overlapping frames restart
    end else if (s_q.frame_left != 4'h0 && s_q.sel_pend == '0 && !s_q.xpend) begin
      s_d.frame_left = s_q.frame_left - 4'h1;
    end

    if (s_q.veto_cnt != 9'h000) s_d.veto_cnt = s_q.veto_cnt - 9'h001;

    // selection: a held crossing drains its expanded object, then inputs
    if (s_q.xpend) begin
      push = 1'b1;
      pw.valid = 1'b1;
      pw.kind = trc_pkg::TRC_KIND_XOBJ;
      pw.check = |hold_err;
      pw.count = s_q.err_cnt;
      pw.data = xobj_mem[s_q.hold];
      s_d.xpend = 1'b0;
    end else if (any_in) begin
      push = 1'b1;
      pw.valid = 1'b1;
      pw.kind = trc_pkg::TRC_KIND_INPUT;
      pw.chan = 7'(first_in);
      pw.check = |hold_err;
      pw.count = s_q.err_cnt;
      pw.data = in_mem[s_q.hold][32'(first_in)*32 +: 32];
      s_d.sel_pend[first_in] = 1'b0;
      if (s_d.sel_pend == '0) s_d.veto_cnt = s_q.veto_len;
    end else if (s_q.frame_left != 4'h0) begin
      push = 1'b1;
      pw.valid = 1'b1;
      pw.check = |mem_err;
      pw.count = s_q.err_cnt;
      s_d.hold = s_q.rptr;
      if (obj_mem[s_q.rptr] != 32'h00000000) begin
        pw.kind = trc_pkg::TRC_KIND_OBJ;
        pw.data = obj_mem[s_q.rptr];
        s_d.xpend = s_q.xobj_en && (xobj_mem[s_q.rptr] != 32'h00000000);
      end else if (s_q.xobj_en && xobj_mem[s_q.rptr] != 32'h00000000) begin
        pw.kind = trc_pkg::TRC_KIND_XOBJ;
        pw.data = xobj_mem[s_q.rptr];
      end else begin
        pw.kind = trc_pkg::TRC_KIND_FLOW;
      end
      if (s_q.veto_cnt == 9'h000) begin
        s_d.sel_pend = (s_q.all_in ? {NCH{1'b1}} : mem_err) & ~s_q.mask;
      end
    end

    // buffer: flow words never enter, so they never reach the drivers
    if (push && pw.kind == trc_pkg::TRC_KIND_FLOW) push = 1'b0;
    pop = (s_q.fcnt != '0);
    s_d.out = '0;
    if (pop) begin
      s_d.out = fifo[s_q.frd];
      s_d.frd = s_q.frd + FW'(1);
    end
    s_d.out_b = s_d.dual ? s_d.out : '0;
    // clear first, so an overflow in the same cycle still sets the flag
    if (clr) s_d.ovf = 1'b0;
    if (push && (s_q.fcnt != (FW + 1)'(FIFO_DEPTH) || pop)) begin
      s_d.fwr = s_q.fwr + FW'(1);
    end else if (push) begin
      s_d.ovf = 1'b1;
      push = 1'b0;
    end
    s_d.fcnt = s_q.fcnt + (FW + 1)'(push) - (FW + 1)'(pop);

    if (rst) begin
      s_d = '0;
      s_d.veto_len = trc_pkg::VETO_RST;
      s_d.delay = AW'(trc_pkg::DELAY_RST);
      s_d.frame = trc_pkg::FRAME_RST;
    end
  end

  always_ff @(posedge clock) begin
    s_q <= s_d;
    if (push) fifo[s_q.fwr] <= pw;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp = s_q.rsp;
  assign rt_data = s_q.rt;
  assign ro_word_a = s_q.out;
  assign ro_word_b = s_q.out_b;
  assign fifo_overflow = s_q.ovf;

endmodule // trc_capture
`default_nettype wire

//--- trc_capture_checker.sv
`timescale 1ns/1ns
`default_nettype none
module trc_capture_checker #(
  parameter int NCH = 104
) (
  input wire logic clock,
  input wire logic rst,
  input wire trc_pkg::trc_apb_req_t apb_req,
  input wire trc_pkg::trc_apb_rsp_t apb_rsp,
  input wire logic [NCH-1:0] in_valid,
  input wire logic [NCH*32-1:0] in_data,
  input wire logic [NCH*10-1:0] in_crc_ok_n,
  input wire logic level1_accept,
  input wire logic [NCH*32-1:0] rt_data,
  input wire trc_pkg::trc_word_t ro_word_a,
  input wire trc_pkg::trc_word_t ro_word_b,
  input wire logic fifo_overflow
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam int ACC_LIM = 1000;
  int since_q;
  logic clr_wr;
  assign clr_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr == trc_pkg::ADDR_CLEAR;
  // starts saturated so words without any accept are caught
  always_ff @(posedge clock) begin
    if (rst) begin
      since_q <= ACC_LIM;
    end else if (level1_accept) begin
      since_q <= 0;
    end else if (since_q < ACC_LIM) begin
      since_q <= since_q + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_answer;
    ##[1:3] apb_rsp.pready;
  endsequence
  property p_rt_zero;
    in_valid[0] && |in_crc_ok_n[9:0] |=> rt_data[31:0] == 32'h00000000;
  endproperty
  property p_rt_pass;
    in_valid[0] && in_crc_ok_n[9:0] == 10'h000 |=> rt_data[31:0] == $past(in_data[31:0]);
  endproperty
  property p_no_flow;
    ro_word_a.valid |-> ro_word_a.kind != trc_pkg::TRC_KIND_FLOW;
  endproperty
  property p_copy;
    ro_word_b.valid |-> ro_word_b == ro_word_a;
  endproperty
  property p_ready_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  property p_answer;
    s_setup |-> s_answer;
  endproperty
  property p_err_ready;
    apb_rsp.pslverr |-> apb_rsp.pready;
  endproperty
  property p_ovf_sticky;
    fifo_overflow && !clr_wr |=> fifo_overflow;
  endproperty
  property p_needs_accept;
    ro_word_a.valid |-> since_q < ACC_LIM;
  endproperty
  a_rt_zero: assert property (p_rt_zero) else $error("rt zero");
  a_rt_pass: assert property (p_rt_pass) else $error("rt pass");
  a_no_flow: assert property (p_no_flow) else $error("flow out");
  a_copy: assert property (p_copy) else $error("copy");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready");
  a_answer: assert property (p_answer) else $error("no answer");
  a_err_ready: assert property (p_err_ready) else $error("pslverr");
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow");
  a_needs_accept: assert property (p_needs_accept) else $error("no accept");
endmodule // trc_capture_checker
bind trc_capture trc_capture_checker #(.NCH(NCH)) trc_capture_checker_i (
  .clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .in_valid(in_valid), .in_data(in_data), .in_crc_ok_n(in_crc_ok_n),
  .level1_accept(level1_accept), .rt_data(rt_data), .ro_word_a(ro_word_a),
  .ro_word_b(ro_word_b), .fifo_overflow(fifo_overflow)
);
`default_nettype wire

//--- trc_rod_model.sv
`timescale 1ns/1ns
`default_nettype none
module trc_rod_model (
  input wire logic clock,
  input wire logic rst,
  input wire trc_pkg::trc_word_t word_a,
  input wire trc_pkg::trc_word_t word_b,
  output int n_kind[4],
  output int n_b,
  output trc_pkg::trc_word_t last_in
);
  // ----------------------------------------------------------------
  // sink: no ready line, it never stalls the sender
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      n_kind <= '{0, 0, 0, 0};
      n_b <= 0;
      last_in <= '0;
    end else begin
      if (word_a.valid) begin
        n_kind[word_a.kind] <= n_kind[word_a.kind] + 1;
      end
      if (word_a.valid && word_a.kind == trc_pkg::TRC_KIND_INPUT) begin
        last_in <= word_a;
      end
      if (word_b.valid) begin
        n_b <= n_b + 1;
      end
    end
  end
endmodule // trc_rod_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int NCH = 4;
  logic clock;
  logic rst;
  trc_pkg::trc_apb_req_t req;
  trc_pkg::trc_apb_rsp_t rsp;
  logic [NCH-1:0] in_valid;
  logic [NCH*32-1:0] in_data;
  logic [NCH*10-1:0] crc_n;
  logic obj_valid;
  logic xobj_valid;
  logic accept;
  logic [NCH*32-1:0] rt_data;
  trc_pkg::trc_word_t word_a;
  trc_pkg::trc_word_t word_b;
  int n_kind[4];
  int n_b;
  trc_pkg::trc_word_t last_in;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic err;
  trc_capture #(.NCH(NCH)) trc_capture_i (
    .clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .in_valid(in_valid),
    .in_data(in_data), .in_crc_ok_n(crc_n), .obj_valid(obj_valid),
    .obj_data(32'h0000A001), .xobj_valid(xobj_valid), .xobj_data(32'h0000B002),
    .level1_accept(accept), .rt_data(rt_data), .ro_word_a(word_a),
    .ro_word_b(word_b), .fifo_overflow()
  );
  trc_rod_model trc_rod_model_i (
    .clock(clock), .rst(rst), .word_a(word_a), .word_b(word_b),
    .n_kind(n_kind), .n_b(n_b), .last_in(last_in)
  );
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // no local limit: a slave that never answers is left to the watchdog
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clock);
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(nm, e, rd);
  endtask
  // counts are deltas, so earlier traffic does not disturb them
  task automatic frame(input logic [31:0] ctrl, input int na, input int eo, input int ex,
                       input int ei);
    int s[4];
    int sb;
    apb(1'b1, trc_pkg::ADDR_CTRL, ctrl);
    s = n_kind;
    sb = n_b;
    repeat (na) begin
      accept <= 1'b1;
      @(posedge clock);
      accept <= 1'b0;
      repeat (30) @(posedge clock);
    end
    repeat (60) @(posedge clock);
    check("obj", eo, n_kind[0] - s[0]);
    check("xobj", ex, n_kind[1] - s[1]);
    check("input", ei, n_kind[2] - s[2]);
    check("flow", 0, n_kind[3] - s[3]);
    check("copy", ctrl[2] ? eo + ex + ei : 0, n_b - sb);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rchk("ctrl", trc_pkg::ADDR_CTRL, 32'h00000000);
    rchk("veto", trc_pkg::ADDR_VETO, 32'h00000000);
    rchk("delay", trc_pkg::ADDR_DELAY, 32'h00000064);
    rchk("frame", trc_pkg::ADDR_FRAME, 32'h00000003);
    rchk("count", trc_pkg::ADDR_COUNT, 32'h00000000);
    apb(1'b0, 12'h0FC, 32'h00000000);
    check("unmapped", 32'h00000001, {31'h0, err});
  endtask
  task automatic t_errors();
    crc_n[29:20] <= 10'h3FF;
    repeat (3) @(posedge clock);
    check("rt_zero", 32'h00000000, rt_data[95:64]);
    crc_n <= {10'h001, 20'h00000, 10'h001};
    @(posedge clock);
    crc_n <= '0;
    repeat (2) @(posedge clock);
    rchk("count", trc_pkg::ADDR_COUNT, 32'h00000004);
    rchk("latch", trc_pkg::ADDR_LATCH0, 32'h0000000D);
    rchk("status", trc_pkg::ADDR_STATUS, 32'h00000001);
    apb(1'b1, trc_pkg::ADDR_CLEAR, trc_pkg::CLEAR_KEY);
    rchk("count_clr", trc_pkg::ADDR_COUNT, 32'h00000000);
    rchk("latch_clr", trc_pkg::ADDR_LATCH0, 32'h00000000);
    rchk("status_clr", trc_pkg::ADDR_STATUS, 32'h00000000);
  endtask
  task automatic t_readout();
    apb(1'b1, trc_pkg::ADDR_DELAY, 32'h00000008);
    frame(32'h00000004, 1, 3, 0, 0);
    xobj_valid <= 1'b1;
    frame(32'h00000005, 1, 3, 3, 0);
    apb(1'b1, trc_pkg::ADDR_MASK0, 32'h00000003);
    frame(32'h00000002, 1, 3, 0, 6);
    apb(1'b1, trc_pkg::ADDR_MASK0, 32'h00000000);
    obj_valid <= 1'b0;
    xobj_valid <= 1'b0;
    frame(32'h00000000, 1, 0, 0, 0);
    obj_valid <= 1'b1;
    crc_n[19:10] <= 10'h3FF;
    frame(32'h00000000, 1, 3, 0, 3);
    check("last_chan", 32'h00000001, {25'h0, last_in.chan});
    check("check_bit", 32'h00000001, {31'h0, last_in.check});
    rchk("status_err", trc_pkg::ADDR_STATUS, 32'h00000003);
    crc_n <= '0;
    apb(1'b1, trc_pkg::ADDR_FRAME, 32'h00000001);
    apb(1'b1, trc_pkg::ADDR_VETO, 32'h00000100);
    frame(32'h00000002, 2, 2, 0, 4);
  endtask
  initial begin
    rst = 1'b1;
    req = '0;
    in_valid = '1;
    crc_n = '0;
    obj_valid = 1'b1;
    xobj_valid = 1'b0;
    accept = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      in_data[c*32 +: 32] = 32'hC0DE0000 + c;
    end
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_errors();
    t_readout();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
